// ==== ulsi_top.sv ====
/*
 Line status, error tags and interrupt identification on APB.
 Assumes receive and transmit data paths sit outside and
 report characters, reads and writes as one-cycle pulses.
*/
`timescale 1ns/100ps
// How it works
// (RULE1) Data ready on arrival, cleared by read/empty
// (RULE2) Character mode overrun when unread, clears on read
// (RULE3) FIFO full overrun drops the new character
// (RULE4) Parity mismatch sets parity flag
// (RULE5) Zero first stop bit sets framing flag
// (RULE6) Low beyond frame time sets break flag
// (RULE7) Restart after half bit of mark
// (RULE8) Errors tagged per character, shown at head
// (RULE9) Errors raise line status interrupt
// (RULE10) Software may write status bits 6..0
// (RULE11) Holding empty set on move, cleared on write
// (RULE12) FIFO mode holding empty follows FIFO
// (RULE13) Delay empty when FIFO never held two
// (RULE14) Enable change gives immediate transmit interrupt
// (RULE15) Transmitter empty when holding and shifter empty
// (RULE16) Error summary bit, FIFO mode only
// (RULE17) Four interrupt priority levels
// (RULE18) Id read freezes highest pending source
// (RULE19) Id bit 0 low when pending
// (RULE20) Id codes per source, bits 5..4 zero
// (RULE21) Timeout after four idle character times
// (RULE22) Id bits 7..6 show FIFO mode
// (RULE23) FIFO control bit 0 enters FIFO mode
// (RULE24) Source needs own enable and output enable
// (RULE25) Freeze released when read ends
module ulsi_top #(
    parameter int DEPTH = ulsi_pkg::RX_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ulsi_pkg::AW-1:0] paddr,
    input wire logic [ulsi_pkg::DW-1:0] pwdata,
    output logic [ulsi_pkg::DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_input,
    input wire logic sample_tick,
    input wire logic rx_char_done,
    input wire logic [7:0] rx_data,
    input wire logic rx_parity_bit,
    input wire logic rx_stop_bit,
    input wire logic rx_buf_read,
    input wire logic tx_hold_write,
    input wire logic tx_hold_to_shift,
    input wire logic tx_shift_empty,
    input wire logic [4:0] tx_fifo_count,
    input wire logic modem_pending,
    output logic rx_store,
    output logic rx_hold,
    output logic irq
);
    import ulsi_pkg::*;

    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [7:0] ls;
        logic [3:0] ie;
        logic [7:0] ctl;
        logic fen;
        logic [PW:0] cnt;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] errs;
        logic [DEPTH-1:0][2:0] tags;
        logic [9:0] to_cnt;
        logic cto;
        logic hold_pend;
        logic two;
        logic [7:0] dly;
        logic frz;
        logic [3:0] frz_id;
        logic pready;
        logic pslverr;
        logic [DW-1:0] prdata;
        logic irq;
        logic store;
    } ulsi_state_type;

    ulsi_state_type q;
    ulsi_state_type d;

    logic brk_pulse;
    logic setup;
    logic rd_done;
    logic wr_done;
    logic ls_read;
    logic id_read;
    logic push_ev;
    logic do_push;
    logic inc;
    logic pop;
    logic [2:0] tag;
    logic [2:0] head_tag;
    logic head_new;
    logic [3:0] id_live;
    logic [3:0] id_cur;
    logic [9:0] to_lim;
    logic [7:0] dly_lim;
    logic idle_cond;
    logic mapped;

    ulsi_brk u_brk (
        .pclk(pclk),
        .presetn(presetn),
        .serial_input(serial_input),
        .sample_tick(sample_tick),
        .frame_bits(q.ctl[CTL_FRM+:4]),
        .brk_pulse(brk_pulse),
        .rx_hold(rx_hold)
    );

    assign setup = psel && !penable;
    assign rd_done = psel && penable && q.pready && !pwrite;
    assign wr_done = psel && penable && q.pready && pwrite;
    assign ls_read = rd_done && paddr == OFF_LS;
    assign id_read = rd_done && paddr == OFF_ID;
    assign mapped = paddr == OFF_LS || paddr == OFF_ID
        || paddr == OFF_IE || paddr == OFF_CTL;

    assign to_lim = 10'(TO_CHARS * OVS * int'(q.ctl[CTL_FRM+:4]));
    assign dly_lim = 8'((int'(q.ctl[CTL_FRM+:4]) - 1) * OVS);

    // Characters arriving while the restart guard holds are dropped
    assign push_ev = (rx_char_done && !rx_hold) || brk_pulse;

    always_comb begin
        tag = 3'b000;
        if (brk_pulse) begin
            tag[2] = 1'b1; // RULE6
        end else begin
            tag[0] = q.ctl[CTL_PEN] && (^{rx_data, rx_parity_bit}
                ^ !q.ctl[CTL_EVEN]); // RULE4
            tag[1] = !rx_stop_bit; // RULE5
        end
    end

    // Full FIFO keeps its contents; the shifter is overwritten
    assign do_push = push_ev
        && (!q.fen || q.cnt != (PW+1)'(DEPTH)); // RULE3
    // Character mode overwrite keeps count at one
    assign inc = do_push && (q.fen || q.cnt == '0);
    assign pop = rx_buf_read && q.cnt != '0;

    always_comb begin
        head_new = 1'b0;
        head_tag = tag;
        if (!q.fen) begin
            head_new = do_push;
        end else if (pop && q.cnt > (PW+1)'(1)) begin
            head_new = 1'b1;
            head_tag = q.tags[q.rp + PW'(1)]; // RULE8
        end else if (do_push && (q.cnt == '0 || pop)) begin
            head_new = 1'b1;
        end
    end

    // Priority: line status, data, holding empty, modem
    always_comb begin
        if (q.ie[IE_RLS] && |q.ls[LS_BRK:LS_OE]) begin // RULE9
            id_live = ID_RLS; // RULE17
        end else if (q.ie[IE_RDA] && q.cto) begin
            id_live = ID_CTO; // RULE20
        end else if (q.ie[IE_RDA] && q.ls[LS_RDY]) begin
            id_live = ID_RDA;
        end else if (q.ie[IE_HOLD] && q.hold_pend) begin
            id_live = ID_HOLD;
        end else if (q.ie[IE_MS] && modem_pending) begin
            id_live = ID_MS;
        end else begin
            id_live = ID_NONE; // RULE19
        end
    end

    assign id_cur = q.frz ? q.frz_id : id_live; // RULE18

    always_comb begin
        if (!q.fen) begin
            idle_cond = q.ls[LS_HOLD] && tx_shift_empty;
        end else begin
            idle_cond = tx_fifo_count == 5'h00 && tx_shift_empty;
        end
    end

    always_comb begin
        d = q;
        d.pready = setup;
        d.pslverr = setup && !mapped;
        d.store = do_push;

        // Read data is caught in setup so the access cycle
        // answers straight from a flop
        if (setup && !pwrite) begin
            d.prdata = '0;
            case (paddr)
                OFF_LS: d.prdata[7:0] = q.ls;
                OFF_ID: begin
                    d.prdata[7:0] = {{2{q.fen}}, 2'b00,
                        id_live}; // RULE22
                    d.frz = 1'b1; // RULE18
                    d.frz_id = id_live;
                end
                OFF_IE: d.prdata[3:0] = q.ie;
                OFF_CTL: d.prdata[7:0] = q.ctl;
                default: d.prdata = '0;
            endcase
        end
        if (rd_done) begin
            d.frz = 1'b0; // RULE25
        end

        // Only bits the reader saw are cleared
        if (ls_read) begin
            d.ls[LS_BRK:LS_OE] = q.ls[LS_BRK:LS_OE]
                & ~q.prdata[LS_BRK:LS_OE]; // RULE2
        end

        if (wr_done) begin
            case (paddr)
                OFF_LS: d.ls[6:0] = pwdata[6:0]; // RULE10
                OFF_ID: d.fen = pwdata[FC_EN]; // RULE23
                OFF_IE: d.ie = pwdata[3:0];
                OFF_CTL: d.ctl = pwdata[7:0];
                default: d.ls = d.ls;
            endcase
        end

        // Receive side
        if (do_push) begin
            d.tags[(!q.fen && q.cnt != '0) ? q.rp : q.wp] = tag;
        end
        if (inc) begin
            d.wp = q.wp + PW'(1);
        end
        if (pop) begin
            d.rp = q.rp + PW'(1);
        end
        d.cnt = q.cnt + (PW+1)'(inc) - (PW+1)'(pop);
        if (q.fen) begin
            d.errs = q.errs + (PW+1)'(do_push && |tag)
                - (PW+1)'(pop && |q.tags[q.rp]); // RULE8
        end else begin
            d.errs = '0;
        end

        if (pop && (!q.fen || d.cnt == '0)) begin
            d.ls[LS_RDY] = 1'b0; // RULE1
        end
        if (do_push) begin
            d.ls[LS_RDY] = 1'b1; // RULE1
        end
        if (push_ev && (q.fen ? q.cnt == (PW+1)'(DEPTH)
            : q.cnt != '0)) begin
            d.ls[LS_OE] = 1'b1; // RULE2
        end
        if (head_new) begin
            d.ls[LS_BRK:LS_PAR] = d.ls[LS_BRK:LS_PAR]
                | {head_tag[2], head_tag[1], head_tag[0]}; // RULE8
        end
        d.ls[LS_ERR] = q.fen && (d.errs != '0
            || (q.ls[LS_ERR] && !ls_read)); // RULE16

        // Character timeout, FIFO mode only
        if (!q.fen || q.cnt == '0 || push_ev || rx_buf_read) begin
            d.to_cnt = '0;
        end else if (sample_tick && q.to_cnt != to_lim) begin
            d.to_cnt = q.to_cnt + 10'h001;
        end
        if (pop || !q.fen || q.cnt == '0) begin
            d.cto = 1'b0;
        end else if (q.to_cnt == to_lim) begin
            d.cto = 1'b1; // RULE21
        end

        // Transmit side
        if (q.fen) begin
            if (tx_fifo_count >= 5'h02) begin
                d.two = 1'b1;
            end
            if (tx_fifo_count != 5'h00) begin
                d.ls[LS_HOLD] = 1'b0; // RULE12
                d.dly = '0;
            end else if (!q.ls[LS_HOLD]) begin
                if (q.two || q.dly == dly_lim) begin
                    d.ls[LS_HOLD] = 1'b1; // RULE12
                    d.two = 1'b0;
                    d.dly = '0;
                end else if (sample_tick) begin
                    d.dly = q.dly + 8'h01; // RULE13
                end
            end
        end else begin
            d.two = 1'b0;
            d.dly = '0;
            if (tx_hold_write) begin
                d.ls[LS_HOLD] = 1'b0; // RULE11
            end
            if (tx_hold_to_shift) begin
                d.ls[LS_HOLD] = 1'b1; // RULE11
            end
        end
        if (tx_hold_write) begin
            d.ls[LS_IDLE] = 1'b0; // RULE15
        end else if (idle_cond) begin
            d.ls[LS_IDLE] = 1'b1; // RULE15
        end

        if (tx_hold_write || (id_read && q.frz_id == ID_HOLD)) begin
            d.hold_pend = 1'b0; // RULE20
        end
        if ((d.ls[LS_HOLD] && !q.ls[LS_HOLD])
            || d.fen != q.fen) begin
            d.hold_pend = 1'b1; // RULE14
        end

        d.irq = q.ctl[CTL_OUTEN] && id_cur != ID_NONE; // RULE24
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.ls <= RST_LS;
            q.ie <= RST_IE;
            q.ctl <= RST_CTL;
            q.frz_id <= ID_NONE;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign irq = q.irq;
    assign rx_store = q.store;

    a_ready_on_push: assert property ( // RULE1
        @(posedge pclk) disable iff (!presetn)
        do_push |=> q.ls[LS_RDY] && q.store)
        else $error("data ready not set on push");

    a_oe_char: assert property ( // RULE2
        @(posedge pclk) disable iff (!presetn)
        !q.fen && push_ev && q.cnt != '0 |=> q.ls[LS_OE])
        else $error("overrun missed in character mode");

    a_oe_full: assert property ( // RULE3
        @(posedge pclk) disable iff (!presetn)
        q.fen && push_ev && q.cnt == (PW+1)'(DEPTH) && !pop
        |=> q.ls[LS_OE] && q.cnt == (PW+1)'(DEPTH) && !q.store)
        else $error("full fifo overrun wrong");

    a_frame_char: assert property ( // RULE5
        @(posedge pclk) disable iff (!presetn)
        !q.fen && rx_char_done && !rx_hold && !brk_pulse
        && !rx_stop_bit |=> q.ls[LS_STOP])
        else $error("framing flag not set");

    a_freeze_hold: assert property ( // RULE18
        @(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == OFF_ID
        |=> q.frz && q.prdata[3:0] == q.frz_id)
        else $error("id not frozen on read");

    a_id_upper: assert property ( // RULE22
        @(posedge pclk) disable iff (!presetn)
        q.pready && paddr == OFF_ID && !pwrite
        |-> q.prdata[7:4] == {{2{q.fen}}, 2'b00})
        else $error("id upper bits wrong");

    a_irq_rls: assert property ( // RULE9
        @(posedge pclk) disable iff (!presetn)
        q.ctl[CTL_OUTEN] && !q.frz && q.ie[IE_RLS]
        && |q.ls[LS_BRK:LS_OE] |=> q.irq)
        else $error("line status interrupt missing");

    a_irq_gate: assert property ( // RULE24
        @(posedge pclk) disable iff (!presetn)
        !q.ctl[CTL_OUTEN] |=> !q.irq)
        else $error("interrupt without output enable");

    a_err_sum: assert property ( // RULE16
        @(posedge pclk) disable iff (!presetn)
        !q.fen |=> !q.ls[LS_ERR])
        else $error("error summary set in character mode");

    a_cto_set: assert property ( // RULE21
        @(posedge pclk) disable iff (!presetn)
        q.fen && q.cnt != '0 && q.to_cnt == to_lim && !pop
        |=> q.cto)
        else $error("character timeout missed");

    a_idle_clr: assert property ( // RULE15
        @(posedge pclk) disable iff (!presetn)
        tx_hold_write && !(wr_done && paddr == OFF_LS)
        |=> !q.ls[LS_IDLE])
        else $error("transmitter empty not cleared");

    a_hold_fifo: assert property ( // RULE12
        @(posedge pclk) disable iff (!presetn)
        q.fen && d.fen && tx_fifo_count != 5'h00
        && !(wr_done && paddr == OFF_LS) |=> !q.ls[LS_HOLD])
        else $error("holding empty with data in fifo");
endmodule : ulsi_top

// ==== ulsi_pkg.sv ====
/*
 Constants for the line status and interrupt id block.
 Assumes a 16x sample tick from a baud generator elsewhere.
*/
package ulsi_pkg;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam logic [7:0] OFF_LS = 8'h00;
    localparam logic [7:0] OFF_ID = 8'h04;
    localparam logic [7:0] OFF_IE = 8'h08;
    localparam logic [7:0] OFF_CTL = 8'h0C;
    localparam int LS_RDY = 0;
    localparam int LS_OE = 1;
    localparam int LS_PAR = 2;
    localparam int LS_STOP = 3;
    localparam int LS_BRK = 4;
    localparam int LS_HOLD = 5;
    localparam int LS_IDLE = 6;
    localparam int LS_ERR = 7;
    localparam int IE_RDA = 0;
    localparam int IE_HOLD = 1;
    localparam int IE_RLS = 2;
    localparam int IE_MS = 3;
    localparam int FC_EN = 0;
    localparam int CTL_PEN = 0;
    localparam int CTL_EVEN = 1;
    localparam int CTL_OUTEN = 3;
    localparam int CTL_FRM = 4;
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_RLS = 4'h6;
    localparam logic [3:0] ID_RDA = 4'h4;
    localparam logic [3:0] ID_CTO = 4'hC;
    localparam logic [3:0] ID_HOLD = 4'h2;
    localparam logic [3:0] ID_MS = 4'h0;
    localparam logic [7:0] RST_LS = 8'h60;
    localparam logic [3:0] RST_IE = 4'h0;
    localparam logic [7:0] RST_CTL = 8'hA0;
    localparam int OVS = 16;
    localparam int HALF_BIT = 8;
    localparam int TO_CHARS = 4;
    localparam int RX_DEPTH = 16;
endpackage : ulsi_pkg

// ==== ulsi_brk.sv ====
/*
 Break detector and restart guard for the receive line.
 Assumes sample_tick is a one-cycle pulse at 16x bit rate.
*/
`timescale 1ns/100ps
module ulsi_brk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic serial_input,
    input wire logic sample_tick,
    input wire logic [3:0] frame_bits,
    output logic brk_pulse,
    output logic rx_hold
);
    import ulsi_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic [7:0] lo;
        logic [3:0] hi;
        logic hold;
        logic pulse;
    } ulsi_brk_type;

    ulsi_brk_type q;
    ulsi_brk_type d;
    logic [7:0] lim;

    assign lim = 8'(int'(frame_bits) * OVS);

    always_comb begin
        d = q;
        d.s1 = serial_input;
        d.s2 = q.s1;
        d.pulse = 1'b0;
        if (q.s2) begin
            d.lo = 8'h00;
        end else if (sample_tick && q.lo != 8'hFF) begin
            d.lo = q.lo + 8'h01;
        end
        // Low past a whole frame
        if (!q.s2 && sample_tick && q.lo == lim && !q.hold) begin
            d.pulse = 1'b1; // RULE6
            d.hold = 1'b1;
        end
        // Restart needs half a bit of mark
        if (!q.s2) begin
            d.hi = 4'h0;
        end else if (q.hold && sample_tick) begin
            d.hi = q.hi + 4'h1;
            if (q.hi == 4'(HALF_BIT - 1)) begin
                d.hold = 1'b0; // RULE7
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign brk_pulse = q.pulse;
    assign rx_hold = q.hold;

    a_hold_release: assert property ( // RULE7
        @(posedge pclk) disable iff (!presetn)
        q.hold && !q.s2 |=> q.hold)
        else $error("break hold released while line low");

    a_break_pulse: assert property ( // RULE6
        @(posedge pclk) disable iff (!presetn)
        q.pulse |-> q.hold && $past(!q.s2)
        && q.lo == $past(lim) + 8'h01)
        else $error("break pulse without low line");
endmodule : ulsi_brk

// ==== ulsi_host.sv ====
/*
 Host side model: an APB master issuing register transfers.
 Assumes the slave answers with pready; waits with no cycle count.
*/
`timescale 1ns/100ps
module ulsi_host (
    input wire logic pclk,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ulsi_pkg::AW-1:0] paddr,
    output logic [ulsi_pkg::DW-1:0] pwdata
);
    import ulsi_pkg::*;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // Request held until pready is seen; released only at that edge
    task automatic xfer(input logic w, input logic [AW-1:0] a,
                        input logic [DW-1:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : ulsi_host

// ==== tb.sv ====
/*
 Self-checking bench for the line status and interrupt id block.
 Assumes ulsi_host drives APB; reads are checked by a watcher.
*/
`timescale 1ns/100ps
module tb;
    import ulsi_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, rx_store, rx_hold, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic serial_input = 1'b1;
    logic sample_tick = 1'b0;
    logic rx_char_done = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_parity_bit = 1'b0;
    logic rx_stop_bit = 1'b1;
    logic rx_buf_read = 1'b0;
    logic tx_hold_write = 1'b0;
    logic tx_hold_to_shift = 1'b0;
    logic tx_shift_empty = 1'b1;
    logic [4:0] tx_fifo_count = 5'h00;
    logic modem_pending = 1'b0;
    logic [64:0] want_q[$];
    logic [64:0] e;
    logic [7:0] d;
    logic p;
    int miscompares = 0;
    int checks_done = 0;
    int stores = 0;
    always #2 pclk = ~pclk;
    // Tick every other cycle keeps frame counts short but real
    always @(posedge pclk) sample_tick <= ~sample_tick;
    always @(posedge pclk) if (rx_store === 1'b1) stores++;
    ulsi_host u_host (.pclk(pclk), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    ulsi_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_input(serial_input), .sample_tick(sample_tick),
        .rx_char_done(rx_char_done), .rx_data(rx_data),
        .rx_parity_bit(rx_parity_bit), .rx_stop_bit(rx_stop_bit),
        .rx_buf_read(rx_buf_read), .tx_hold_write(tx_hold_write),
        .tx_hold_to_shift(tx_hold_to_shift),
        .tx_shift_empty(tx_shift_empty), .tx_fifo_count(tx_fifo_count),
        .modem_pending(modem_pending), .rx_store(rx_store),
        .rx_hold(rx_hold), .irq(irq));
    task automatic chk(input string nm, input logic [32:0] seen,
                       input logic [32:0] want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, want, seen);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    // Upper data bits must always read zero, so they stay in the mask
    task automatic rd(input logic [7:0] a, input logic [7:0] v,
                      input logic [7:0] m = 8'hFF, input logic er = 1'b0);
        want_q.push_back({er, 24'hFFFFFF, m, 24'h000000, v});
        u_host.xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        u_host.xfer(1'b1, a, {24'h000000, v});
    endtask : wr
    task automatic rxc(input logic [7:0] dv, input logic pb, input logic sb);
        @(posedge pclk);
        rx_char_done <= 1'b1;
        rx_data <= dv;
        rx_parity_bit <= pb;
        rx_stop_bit <= sb;
        @(posedge pclk);
        rx_char_done <= 1'b0;
        @(posedge pclk);
    endtask : rxc
    task automatic pls(input logic [2:0] m);
        @(posedge pclk);
        {tx_hold_to_shift, tx_hold_write, rx_buf_read} <= m;
        @(posedge pclk);
        {tx_hold_to_shift, tx_hold_write, rx_buf_read} <= 3'h0;
    endtask : pls
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = want_q.pop_front();
            chk("prdata", {pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
        end
    end
    initial begin
        #50000;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        d = 8'($urandom(32'h9B3A));
        rd(OFF_LS, 8'h60);
        rd(OFF_ID, 8'h01);
        rd(8'h10, 8'h00, 8'hFF, 1'b1);
        wr(OFF_CTL, 8'hAB);
        wr(OFF_IE, 8'h05);
        d = 8'($urandom);
        rxc(d, ^d, 1'b1);
        rd(OFF_LS, 8'h61);
        rd(OFF_ID, 8'h04);
        chk("irq", {32'h0, irq}, 33'h1);
        d = 8'($urandom);
        rxc(d, ^d, 1'b1);
        rd(OFF_ID, 8'h06);
        rd(OFF_LS, 8'h63);
        rd(OFF_LS, 8'h61);
        pls(3'b001);
        rd(OFF_LS, 8'h60);
        rd(OFF_ID, 8'h01);
        wr(OFF_IE, 8'h08);
        modem_pending <= 1'b1;
        rd(OFF_ID, 8'h00);
        modem_pending <= 1'b0;
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 3; k++) begin
                wr(OFF_CTL, 8'hA9 | 8'(m << 1));
                wr(OFF_IE, 8'h05);
                d = 8'($urandom);
                p = (m == 1) ? ^d : ~^d;
                rxc(d, (k == 1) ? ~p : p, k != 2);
                rd(OFF_ID, (k == 0) ? 8'h04 : 8'h06);
                rd(OFF_LS, 8'h61 | 8'(k == 1) << 2 | 8'(k == 2) << 3);
                pls(3'b001);
            end
        end
        wr(OFF_IE, 8'h00);
        rxc(8'h01, 1'b0, 1'b1);
        cyc(2);
        chk("irq", {32'h0, irq}, 33'h0);
        rd(OFF_ID, 8'h01);
        wr(OFF_CTL, 8'hA3);
        wr(OFF_IE, 8'h04);
        cyc(2);
        chk("irq", {32'h0, irq}, 33'h0);
        rd(OFF_ID, 8'h06);
        rd(OFF_LS, 8'h65);
        pls(3'b001);
        wr(OFF_CTL, 8'hAB);
        wr(OFF_LS, 8'hFF);
        rd(OFF_LS, 8'h7F);
        rd(OFF_LS, 8'h61);
        wr(OFF_LS, 8'h60);
        serial_input <= 1'b0;
        cyc(400);
        chk("rx_hold", {32'h0, rx_hold}, 33'h1);
        serial_input <= 1'b1;
        cyc(6);
        chk("rx_hold", {32'h0, rx_hold}, 33'h1);
        cyc(30);
        chk("rx_hold", {32'h0, rx_hold}, 33'h0);
        rd(OFF_LS, 8'h11, 8'h1F);
        pls(3'b001);
        wr(OFF_IE, 8'h02);
        pls(3'b010);
        rd(OFF_LS, 8'h00, 8'h60);
        tx_shift_empty <= 1'b0;
        pls(3'b100);
        cyc(2);
        chk("irq", {32'h0, irq}, 33'h1);
        rd(OFF_LS, 8'h20, 8'h60);
        rd(OFF_ID, 8'h02);
        rd(OFF_ID, 8'h01);
        tx_shift_empty <= 1'b1;
        rd(OFF_LS, 8'h60, 8'h60);
        wr(OFF_ID, 8'h01);
        rd(OFF_ID, 8'hC2);
        rd(OFF_ID, 8'hC1);
        tx_fifo_count <= 5'h01;
        tx_shift_empty <= 1'b0;
        pls(3'b010);
        tx_fifo_count <= 5'h02;
        pls(3'b010);
        rd(OFF_LS, 8'h00, 8'h60);
        tx_fifo_count <= 5'h00;
        tx_shift_empty <= 1'b1;
        cyc(4);
        rd(OFF_LS, 8'h60, 8'h60);
        tx_fifo_count <= 5'h01;
        tx_shift_empty <= 1'b0;
        pls(3'b010);
        cyc(4);
        tx_fifo_count <= 5'h00;
        cyc(20);
        rd(OFF_LS, 8'h00, 8'h20);
        cyc(300);
        rd(OFF_LS, 8'h20, 8'h20);
        tx_shift_empty <= 1'b1;
        wr(OFF_IE, 8'h05);
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            rxc(d, (i == 1) ? ~^d : ^d, 1'b1);
        end
        rd(OFF_LS, 8'h81, 8'h9F);
        pls(3'b001);
        rd(OFF_LS, 8'h85, 8'h9F);
        pls(3'b001);
        rd(OFF_LS, 8'h81, 8'h9F);
        pls(3'b001);
        rd(OFF_LS, 8'h00, 8'h81);
        stores = 0;
        for (int i = 0; i < 17; i++) begin
            d = 8'($urandom);
            rxc(d, ^d, 1'b1);
        end
        chk("rx_store", 33'(stores), 33'd16);
        rd(OFF_ID, 8'hC6);
        rd(OFF_LS, 8'h03, 8'h03);
        rd(OFF_ID, 8'hC4);
        cyc(1400);
        rd(OFF_ID, 8'hCC);
        pls(3'b001);
        rd(OFF_ID, 8'hC4);
        repeat (15) pls(3'b001);
        rd(OFF_LS, 8'h00, 8'h01);
        cyc(4);
        summarize();
    end
endmodule : tb
